//--- common/xrm_defs.vh
// Constants for the four-lane rate match FIFO.
// Included by the rate match module by bare name; definitions only.
`ifndef XRM_DEFS_VH
`define XRM_DEFS_VH

// Lane layout: 8 data bits plus a control-character flag per lane
`define XRM_LANES        4
`define XRM_LANE_W       9
`define XRM_R_CODE       8'h1c

// Elastic sizing; 200 ppm total offset drifts one column per 5000
`define XRM_PPM_TOTAL    200
`define XRM_DEPTH        16
`define XRM_HI_MARK      12
`define XRM_LO_MARK      4

// Least hold of the full and empty flags, in clock cycles
`define XRM_FLAG_HOLD    2'd3

// APB register byte offsets
`define XRM_ADDR_CTRL    12'h000
`define XRM_ADDR_STAT    12'h004
`define XRM_ADDR_MASK    12'h008
`define XRM_ADDR_LEVEL   12'h00c

// Control fields
`define XRM_CTRL_EN      0
`define XRM_CTRL_FLUSH   1
`define XRM_CTRL_RST     2'h1

// Status, mask and event fields
`define XRM_EV_DEL       0
`define XRM_EV_INS       1
`define XRM_EV_FULL      2
`define XRM_EV_EMPTY     3
`define XRM_EV_W         4
`define XRM_MASK_RST     4'h0

// Level register fields
`define XRM_LVL_RUN      8
`define XRM_LVL_FULL     9
`define XRM_LVL_EMPTY    10

`endif

//--- hdl/xrm_fifo_mem.v
// Column storage of the rate match FIFO: one write port, one read port.
// Assumes the caller keeps pointers in range and never writes when full.
`timescale 1ns/10ps

module xrm_fifo_mem #(
	parameter WIDTH = 36,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             pclk,
	input  wire             wr_en,
	input  wire [AW-1:0]    wr_addr,
	input  wire [WIDTH-1:0] wr_data,
	input  wire [AW-1:0]    rd_addr,
	output wire [WIDTH-1:0] rd_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];

	// No reset: contents are only read behind the write pointer
	always @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];

endmodule // xrm_fifo_mem

//--- hdl/xrm_rate_match.v
// Four-lane receive rate match FIFO with APB registers and interrupt.
// Assumes lanes arrive word-aligned and deskewed, one column per in_valid,
// and the fabric takes one column per out_take; all on pclk.
`timescale 1ns/10ps
`include "xrm_defs.vh"

module xrm_rate_match #(
	parameter DEPTH   = `XRM_DEPTH,
	parameter HI_MARK = `XRM_HI_MARK,
	parameter LO_MARK = `XRM_LO_MARK
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	input  wire        in_valid,
	input  wire [35:0] in_column,
	input  wire [3:0]  sync_status,
	input  wire        lanes_aligned,
	input  wire        out_take,
	output reg         out_valid,
	output reg  [35:0] out_column,
	output reg  [3:0]  col_deleted,
	output reg  [3:0]  col_inserted,
	output wire        fifo_full,
	output wire        fifo_empty,
	output wire        irq
);

	localparam AW = $clog2(DEPTH);
	localparam LW = AW + 1;
	localparam [LW-1:0] LVL_MAX = DEPTH[LW-1:0];
	localparam [LW-1:0] LVL_HI  = HI_MARK[LW-1:0];
	localparam [LW-1:0] LVL_LO  = LO_MARK[LW-1:0];

	// Idle code group: K28.0 with the control flag set
	function is_r_lane;
		input [`XRM_LANE_W-1:0] lane;
		begin
			is_r_lane = (lane == {1'b1, `XRM_R_CODE});
		end
	endfunction

	// Wrap by compare, so DEPTH need not be a power of two
	function [AW-1:0] ptr_inc;
		input [AW-1:0] ptr;
		begin
			if (ptr == DEPTH - 1) begin
				ptr_inc = {AW{1'b0}};
			end else begin
				ptr_inc = ptr + 1'b1;
			end
		end
	endfunction

	// Hold counter: an event reloads it, so repeated events stretch the flag
	function [1:0] hold_step;
		input       evt;
		input [1:0] cnt;
		begin
			if (evt) begin
				hold_step = `XRM_FLAG_HOLD;
			end else if (cnt != 2'd0) begin
				hold_step = cnt - 2'd1;
			end else begin
				hold_step = 2'd0;
			end
		end
	endfunction

	reg  [1:0]           ctrl_reg;
	reg  [`XRM_EV_W-1:0] stat_reg;
	reg  [`XRM_EV_W-1:0] mask_reg;
	reg  [AW-1:0]        wr_ptr_reg;
	reg  [AW-1:0]        rd_ptr_reg;
	reg  [LW-1:0]        level_reg;
	reg  [1:0]           full_cnt_reg;
	reg  [1:0]           empty_cnt_reg;
	wire [35:0]          head_col;
	wire                 running;
	wire                 in_is_r;
	wire                 do_delete;
	wire                 full_evt;
	wire                 do_push;
	wire                 empty_evt;
	wire                 do_insert;
	wire                 do_pop;
	wire                 flush;
	wire                 apb_setup;
	wire                 apb_wr;
	wire                 stat_rd;
	wire [`XRM_EV_W-1:0] events;
	reg  [31:0]          rd_mux;
	reg                  addr_bad;
	// Next values of the registers above
	reg  [1:0]           ctrl_next;
	reg  [`XRM_EV_W-1:0] stat_next;
	reg  [`XRM_EV_W-1:0] mask_next;
	reg  [AW-1:0]        wr_ptr_next;
	reg  [AW-1:0]        rd_ptr_next;
	reg  [LW-1:0]        level_next;
	wire [3:0]           in_lane_r;
	wire [3:0]           head_lane_r;
	wire                 head_is_r;
	wire                 deliver;
	wire                 ctrl_wr;
	wire                 mask_wr;

	// Matching waits for every lane in sync and the deskew to lock
	assign running = ctrl_reg[`XRM_CTRL_EN] & (&sync_status) & lanes_aligned;

	// Lanes are judged one by one; only an all-idle column may be edited
	genvar g;
	generate
		for (g = 0; g < `XRM_LANES; g = g + 1) begin : g_lane
			assign in_lane_r[g]   = is_r_lane(in_column[g*`XRM_LANE_W +: `XRM_LANE_W]);
			assign head_lane_r[g] = is_r_lane(head_col[g*`XRM_LANE_W +: `XRM_LANE_W]);
		end
	endgenerate

	assign in_is_r   = &in_lane_r;
	assign head_is_r = &head_lane_r;

	// Write side: drop an idle column when running near full
	assign do_delete = in_valid & running & in_is_r & (level_reg >= LVL_HI);
	// A full FIFO drops a non-idle column plainly; an idle one is still deleted while running, with no full event
	assign full_evt  = in_valid & ~do_delete & (level_reg == LVL_MAX);
	assign do_push   = in_valid & ~do_delete & ~full_evt;

	// Read side: repeat an idle head column when running near empty
	assign empty_evt = out_take & (level_reg == {LW{1'b0}});
	assign do_insert = out_take & ~empty_evt & running & head_is_r &
		(level_reg <= LVL_LO);
	assign do_pop    = out_take & ~empty_evt & ~do_insert;
	// A delivered column is either a pop or a repeated idle head
	assign deliver   = do_pop | do_insert;

	xrm_fifo_mem #(
		.WIDTH   (36),
		.DEPTH   (DEPTH),
		.AW      (AW)
	) u_mem (
		.pclk    (pclk),
		.wr_en   (do_push),
		.wr_addr (wr_ptr_reg),
		.wr_data (in_column),
		.rd_addr (rd_ptr_reg),
		.rd_data (head_col)
	);

	// Marks keep DEPTH-HI columns of headroom for the ppm drift
	always @* begin
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		level_next  = level_reg;
		if (flush) begin
			wr_ptr_next = {AW{1'b0}};
			rd_ptr_next = {AW{1'b0}};
			level_next  = {LW{1'b0}};
		end else begin
			if (do_push) begin
				wr_ptr_next = ptr_inc(wr_ptr_reg);
			end
			if (do_pop) begin
				rd_ptr_next = ptr_inc(rd_ptr_reg);
			end
			if (do_push & ~do_pop) begin
				level_next = level_reg + 1'b1;
			end else if (do_pop & ~do_push) begin
				level_next = level_reg - 1'b1;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			level_reg  <= {LW{1'b0}};
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			level_reg  <= level_next;
		end
	end

	// Output column register and per-lane edit strobes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid    <= 1'b0;
			out_column   <= 36'h0;
			col_deleted  <= 4'h0;
			col_inserted <= 4'h0;
		end else begin
			out_valid    <= deliver;
			col_deleted  <= {`XRM_LANES{do_delete}};
			col_inserted <= {`XRM_LANES{do_insert}};
			if (deliver) begin
				out_column <= head_col;
			end
		end
	end

	// Flags stretch so a slow fabric sampler still sees them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_cnt_reg  <= 2'd0;
			empty_cnt_reg <= 2'd0;
		end else begin
			full_cnt_reg  <= hold_step(full_evt, full_cnt_reg);
			empty_cnt_reg <= hold_step(empty_evt, empty_cnt_reg);
		end
	end

	// Flags hold for XRM_FLAG_HOLD cycles after the last event, then clear
	assign fifo_full  = (full_cnt_reg != 2'd0);
	assign fifo_empty = (empty_cnt_reg != 2'd0);

	// APB slave: zero wait states, read data captured in the setup cycle
	assign pready    = 1'b1;
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pwrite;
	assign stat_rd   = psel & penable & ~pwrite & (paddr == `XRM_ADDR_STAT);
	assign ctrl_wr   = apb_wr & (paddr == `XRM_ADDR_CTRL);
	assign mask_wr   = apb_wr & (paddr == `XRM_ADDR_MASK);
	// Flush empties the FIFO but leaves the flags to run out their hold
	assign flush     = ctrl_wr & pwdata[`XRM_CTRL_FLUSH];

	always @* begin
		rd_mux   = 32'h0;
		addr_bad = 1'b0;
		case (paddr)
			`XRM_ADDR_CTRL:  rd_mux = {31'h0, ctrl_reg[`XRM_CTRL_EN]};
			`XRM_ADDR_STAT:  rd_mux = {28'h0, stat_reg};
			`XRM_ADDR_MASK:  rd_mux = {28'h0, mask_reg};
			`XRM_ADDR_LEVEL: rd_mux = {21'h0, fifo_empty, fifo_full, running,
				{(8 - LW){1'b0}}, level_reg};
			default:         addr_bad = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (apb_setup) begin
			prdata  <= pwrite ? 32'h0 : rd_mux;
			pslverr <= addr_bad;
		end
	end

	assign events = {empty_evt, full_evt, do_insert, do_delete};

	// Sticky status: a read clears only the bits it returned, so an event
	// landing between the setup and access edges is kept
	always @* begin
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		stat_next = stat_reg | events;
		if (stat_rd) begin
			stat_next = (stat_reg & ~prdata[`XRM_EV_W-1:0]) | events;
		end
		if (ctrl_wr) begin
			ctrl_next = {1'b0, pwdata[`XRM_CTRL_EN]};
		end
		if (mask_wr) begin
			mask_next = pwdata[`XRM_EV_W-1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `XRM_CTRL_RST;
			mask_reg <= `XRM_MASK_RST;
			stat_reg <= {`XRM_EV_W{1'b0}};
		end else begin
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			stat_reg <= stat_next;
		end
	end

	assign irq = |(stat_reg & mask_reg);

endmodule // xrm_rate_match

//--- tb/xrm_rate_match_props.sv
// Port checker for the rate match FIFO.
// Bound to the top module from the testbench file.
`timescale 1ns/10ps
module xrm_rate_match_props (
	input logic        pclk,
	input logic        presetn,
	input logic        in_valid,
	input logic [35:0] in_column,
	input logic [3:0]  sync_status,
	input logic        lanes_aligned,
	input logic        out_take,
	input logic        out_valid,
	input logic [3:0]  col_deleted,
	input logic [3:0]  col_inserted,
	input logic        fifo_full,
	input logic        fifo_empty
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	localparam logic [35:0] IDL = {4{9'h11c}};
	chk_del_whole: assert property (col_deleted == 4'h0 || col_deleted == 4'hf)
		else $error("partial deletion");
	chk_ins_whole: assert property (col_inserted == 4'h0 || col_inserted == 4'hf)
		else $error("partial insertion");
	chk_del_idle_only: assert property (col_deleted[0] |-> $past(in_valid) && $past(in_column) == IDL)
		else $error("deletion without idle column");
	chk_ins_on_take: assert property (col_inserted[0] |-> $past(out_take) && out_valid)
		else $error("insertion without delivery");
	chk_no_edit_unlocked: assert property ($past(sync_status) != 4'hf || !$past(lanes_aligned)
		|-> col_deleted == 4'h0 && col_inserted == 4'h0) else $error("edit before lock");
	chk_full_hold: assert property ($rose(fifo_full) |-> fifo_full[*3])
		else $error("full flag too short");
	chk_empty_hold: assert property ($rose(fifo_empty) |-> fifo_empty[*3])
		else $error("empty flag too short");
	chk_empty_cause: assert property ($rose(fifo_empty) |-> $past(out_take) && !out_valid)
		else $error("empty without take");
	chk_full_no_edit: assert property ($rose(fifo_full) |-> $past(in_valid) && col_deleted == 4'h0)
		else $error("full with deletion");
	cover property (col_deleted[0]);
	cover property (col_inserted[0]);
	cover property ($rose(fifo_full));
	cover property ($rose(fifo_empty));
endmodule // xrm_rate_match_props

//--- tb/xrm_fabric_model.sv
// Fabric side model: takes columns on request, asks for reset on full or empty.
// Runs on the FIFO clock; its reset request clears only with presetn.
`timescale 1ns/10ps
module xrm_fabric_model (
	input  logic pclk,
	input  logic presetn,
	input  logic take_en,
	input  logic fifo_full,
	input  logic fifo_empty,
	output logic out_take,
	output logic rst_req
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_take <= 0;
			rst_req  <= 0;
		end else begin
			// Stop taking once reset is wanted, so empty events do not pile up
			rst_req  <= rst_req | fifo_full | fifo_empty;
			out_take <= take_en & !rst_req & !(fifo_full | fifo_empty);
		end
	end
endmodule // xrm_fabric_model

//--- tb/xrm_rate_match_tb.sv
// Bench for the rate match FIFO: idle edits, full, empty, APB status.
// Fabric side is the take model; one 40 MHz clock.
`timescale 1ns/10ps
module xrm_rate_match_tb;
	localparam logic [35:0] IDL = {4{9'h11c}}, DAT = {4{9'h0aa}};
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, in_valid = 0, lanes_aligned = 0;
	logic        take_en = 0, out_take, out_valid, pready, pslverr, fifo_full, fifo_empty, irq, rst_req, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [35:0] in_column = 0, out_column;
	logic [3:0]  sync_status = 0, col_deleted, col_inserted;
	int          n_errors = 0, num_checks = 0;
	always #12.5 pclk = ~pclk;
	xrm_rate_match xrm_rate_match_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.in_valid(in_valid), .in_column(in_column), .sync_status(sync_status), .lanes_aligned(lanes_aligned),
		.out_take(out_take), .out_valid(out_valid), .out_column(out_column), .col_deleted(col_deleted),
		.col_inserted(col_inserted), .fifo_full(fifo_full), .fifo_empty(fifo_empty), .irq(irq));
	xrm_fabric_model xrm_fabric_model_inst (.pclk(pclk), .presetn(presetn), .take_en(take_en),
		.fifo_full(fifo_full), .fifo_empty(fifo_empty), .out_take(out_take), .rst_req(rst_req));
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk) begin
			psel <= 1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
		end
		@(posedge pclk) penable <= 1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 20)
			chk(0, 1);
		if (k == 20)
			final_report;
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic push(input logic [35:0] c);
		@(posedge pclk) begin
			in_valid <= 1;
			in_column <= c;
		end
		@(posedge pclk) in_valid <= 0;
		#1;
	endtask
	task automatic wait_for(input int which);
		int k;
		for (k = 0; k < 40 && (which ? fifo_empty : col_inserted[0]) !== 1'b1; k++)
			@(posedge pclk) #1;
		if (k == 40) begin
			chk(0, 1);
			final_report;
		end
	endtask
	task automatic do_reset;
		@(posedge pclk) presetn <= 0;
		repeat (6) @(posedge pclk);
		presetn <= 1;
	endtask
	task automatic t_gate_delete;
		repeat (14) push(IDL);
		chk(col_deleted, 0);
		apb(0, 12'h00c, 0);
		chk(rd[8:0], 9'h00e);
		apb(0, 12'h010, 0);
		chk(err, 1);
		@(posedge pclk) begin
			sync_status <= 4'hf;
			lanes_aligned <= 1;
		end
		push(IDL);
		chk(col_deleted, 4'hf);
		@(posedge pclk) #1;
		chk(col_deleted, 0);
		repeat (6) push(IDL);
		chk(fifo_full, 0);
		apb(0, 12'h00c, 0);
		chk(rd[8:0], 9'h10e);
		apb(1, 12'h000, 32'h0);
		apb(0, 12'h00c, 0);
		chk(rd[8], 1'b0);
		push(IDL);
		chk(col_deleted, 0);
		apb(1, 12'h000, 32'h1);
	endtask
	task automatic t_insert;
		@(posedge pclk) take_en <= 1;
		wait_for(0);
		chk(col_inserted, 4'hf);
		chk(out_column, IDL);
		@(posedge pclk) take_en <= 0;
	endtask
	task automatic t_full;
		apb(1, 12'h008, 32'h4);
		repeat (12) push(DAT);
		chk(fifo_full, 0);
		push(DAT);
		@(posedge pclk) #1;
		chk(fifo_full, 1);
		chk(irq, 1);
		apb(0, 12'h004, 0);
		chk(rd[3:0], 4'h7);
		@(posedge pclk) #1;
		chk(irq, 0);
		chk(rst_req, 1);
		do_reset;
		apb(0, 12'h00c, 0);
		chk(rd[9:0], 10'h100);
	endtask
	task automatic t_empty;
		apb(1, 12'h008, 32'h8);
		push(DAT);
		push(DAT);
		apb(1, 12'h000, 32'h3);
		apb(0, 12'h00c, 0);
		chk(rd[9:0], 10'h100);
		@(posedge pclk) take_en <= 1;
		wait_for(1);
		chk(fifo_empty, 1);
		chk(out_valid, 0);
		chk(irq, 1);
		@(posedge pclk) take_en <= 0;
		do_reset;
		@(posedge pclk) #1;
		chk(fifo_empty, 0);
	endtask
	initial begin
		do_reset;
		t_gate_delete;
		t_insert;
		t_full;
		t_empty;
		final_report;
	end
endmodule // xrm_rate_match_tb
bind xrm_rate_match xrm_rate_match_props xrm_rate_match_props_inst (.pclk(pclk), .presetn(presetn),
	.in_valid(in_valid), .in_column(in_column), .sync_status(sync_status), .lanes_aligned(lanes_aligned),
	.out_take(out_take), .out_valid(out_valid), .col_deleted(col_deleted), .col_inserted(col_inserted),
	.fifo_full(fifo_full), .fifo_empty(fifo_empty));
